// ### pdl_diag_led.sv
`include "pdl_consts.svh"
`default_nettype none
module pdl_diag_led #(
  parameter int BLINK_CYCLES = `PDL_BLINK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic an_done,
  input wire logic an_fail,
  input wire logic an_full_duplex,
  input wire logic an_speed_100,
  input wire logic rx_signal_detected,
  input wire logic rx_pll_lock,
  input wire logic link_up,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic speed_100,
  input wire logic full_duplex,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rdata_valid,
  output logic [15:0] tx_gain,
  output logic led_primary,
  output logic led_secondary
);

  logic neg_fail_flag_reg;
  logic duplex_result_reg;
  logic speed_result_reg;
  logic rx_signal_detected_reg;
  logic rx_lock_reg;
  logic [15:0] transceiver_gain_control_reg;
  logic [`PDL_LED_CFG_W-1:0] led_source_config_reg;
  logic [15:0] an_diagnostic_status;
  logic [15:0] rdata_next;
  logic diag_read;
  logic [31:0] blink_cnt_reg;
  logic blink_tick;
  logic act_pend_reg;
  logic act_show_reg;
  logic blink_phase_reg;
  logic [1:0] led_vec;

  // read strobe aimed at the diagnostic register
  assign diag_read = mgmt_rd && (mgmt_addr == `PDL_ADDR_DIAG);

  // failure flag: a new failure in the read cycle wins over the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      neg_fail_flag_reg <= 1'b0;
    end else if (an_done && an_fail) begin
      neg_fail_flag_reg <= 1'b1;
    end else if (diag_read) begin
      neg_fail_flag_reg <= 1'b0;
    end
  end

  // resolved mode, latched when negotiation succeeds
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      duplex_result_reg <= 1'b0;
      speed_result_reg <= 1'b0;
    end else if (an_done && !an_fail) begin
      duplex_result_reg <= an_full_duplex;
      speed_result_reg <= an_speed_100;
    end
  end

  // live receive status, sampled once per clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_signal_detected_reg <= 1'b0;
      rx_lock_reg <= 1'b0;
    end else begin
      rx_signal_detected_reg <= rx_signal_detected;
      rx_lock_reg <= rx_pll_lock;
    end
  end

  // diagnostic image; every other bit is tied low
  always_comb begin
    an_diagnostic_status = `PDL_RST_DIAG;
    an_diagnostic_status[`PDL_DIAG_FAIL_BIT] = neg_fail_flag_reg;
    an_diagnostic_status[`PDL_DIAG_DUPLEX_BIT] = duplex_result_reg;
    an_diagnostic_status[`PDL_DIAG_SPEED_BIT] = speed_result_reg;
    an_diagnostic_status[`PDL_DIAG_RXDET_BIT] = rx_signal_detected_reg;
    an_diagnostic_status[`PDL_DIAG_LOCK_BIT] = rx_lock_reg;
  end

  // gain control, full 16 bits writable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transceiver_gain_control_reg <= `PDL_RST_GAIN;
    end else if (mgmt_wr && (mgmt_addr == `PDL_ADDR_GAIN)) begin
      transceiver_gain_control_reg <= mgmt_wdata;
    end
  end

  // led config keeps only the two source fields; upper byte is not stored
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      led_source_config_reg <= `PDL_RST_LED;
    end else if (mgmt_wr && (mgmt_addr == `PDL_ADDR_LED)) begin
      led_source_config_reg <= mgmt_wdata[`PDL_LED_CFG_W-1:0];
    end
  end

  // writes to the diagnostic address fall through untouched
  always_comb begin
    rdata_next = 16'h0000;
    case (mgmt_addr)
      `PDL_ADDR_DIAG: rdata_next = an_diagnostic_status;
      `PDL_ADDR_GAIN: rdata_next = transceiver_gain_control_reg;
      `PDL_ADDR_LED: rdata_next = {8'h00, led_source_config_reg};
      default: rdata_next = 16'h0000;
    endcase
  end

  // read answer one cycle after the strobe, holds until next read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      mgmt_rdata <= rdata_next;
    end
  end

  // valid follows the read strobe one cycle late, high for as many cycles as mgmt_rd
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata_valid <= 1'b0;
    end else begin
      mgmt_rdata_valid <= mgmt_rd;
    end
  end

  // gain setting driven out to the analog transmitter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_gain <= `PDL_RST_GAIN;
    end else begin
      tx_gain <= transceiver_gain_control_reg;
    end
  end

  // divider giving the blink half period as a one-cycle enable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt_reg <= 32'h0000_0000;
    end else if (blink_tick) begin
      blink_cnt_reg <= 32'h0000_0000;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  assign blink_tick = (blink_cnt_reg == 32'(BLINK_CYCLES - 1));

  // activity stretch: single packets would be invisible without it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_pend_reg <= 1'b0;
      act_show_reg <= 1'b0;
    end else if (blink_tick) begin
      act_show_reg <= act_pend_reg | rx_activity | tx_activity;
      act_pend_reg <= 1'b0;
    end else if (rx_activity || tx_activity) begin
      act_pend_reg <= 1'b1;
    end
  end

  // blink phase flips each half period
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      blink_phase_reg <= 1'b0;
    end else if (blink_tick) begin
      blink_phase_reg <= ~blink_phase_reg;
    end
  end

  // one driver per led; index 0 primary, index 1 secondary
  generate
    for (genvar i = 0; i < 2; i++) begin : g_led
      pdl_led_drive u_drive (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .src_code(led_source_config_reg[i*`PDL_LED_FIELD_W +: `PDL_LED_FIELD_W]),
        .link_up(link_up),
        .act_show(act_show_reg),
        .blink_phase(blink_phase_reg),
        .speed_100(speed_100),
        .full_duplex(full_duplex),
        .led_out(led_vec[i])
      );
    end
  endgenerate

  assign led_primary = led_vec[0];
  assign led_secondary = led_vec[1];

endmodule : pdl_diag_led
`default_nettype wire

// ### pdl_consts.svh
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH

// management addresses
`define PDL_ADDR_DIAG 5'h12
`define PDL_ADDR_GAIN 5'h13
`define PDL_ADDR_LED 5'h17

// reset values
`define PDL_RST_DIAG 16'h0000
`define PDL_RST_GAIN 16'h4000
`define PDL_RST_LED 8'h10

// diagnostic field positions
`define PDL_DIAG_FAIL_BIT 12
`define PDL_DIAG_DUPLEX_BIT 11
`define PDL_DIAG_SPEED_BIT 10
`define PDL_DIAG_RXDET_BIT 9
`define PDL_DIAG_LOCK_BIT 8

// led field positions and width
`define PDL_LED_FIELD_W 4
`define PDL_LED_PRI_LSB 0
`define PDL_LED_SEC_LSB 4
`define PDL_LED_CFG_W 8

// blink timing
`define PDL_CLK_MHZ 100
`define PDL_BLINK_MS 40
`define PDL_BLINK_CYCLES (`PDL_BLINK_MS * 1000 * `PDL_CLK_MHZ)

`endif

// ### pdl_pkg.sv
`default_nettype none
package pdl_pkg;

  // led source selection codes
  typedef enum logic [3:0] {
    PDL_SRC_LINK = 4'h0,
    PDL_SRC_ACT = 4'h1,
    PDL_SRC_RSV2 = 4'h2,
    PDL_SRC_RSV3 = 4'h3,
    PDL_SRC_RSV4 = 4'h4,
    PDL_SRC_100 = 4'h5,
    PDL_SRC_10 = 4'h6,
    PDL_SRC_FDX = 4'h7,
    PDL_SRC_LINK_BLINK = 4'h8
  } pdl_led_src_t;

endpackage : pdl_pkg
`default_nettype wire

// ### pdl_led_drive.sv
`default_nettype none
module pdl_led_drive (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] src_code,
  input wire logic link_up,
  input wire logic act_show,
  input wire logic blink_phase,
  input wire logic speed_100,
  input wire logic full_duplex,
  output logic led_out
);

  logic led_next;

  // decode of the source code; anything unlisted keeps the led dark
  always_comb begin
    led_next = 1'b0;
    case (src_code)
      pdl_pkg::PDL_SRC_LINK: led_next = link_up;
      pdl_pkg::PDL_SRC_ACT: led_next = act_show;
      pdl_pkg::PDL_SRC_100: led_next = speed_100;
      pdl_pkg::PDL_SRC_10: led_next = ~speed_100;
      pdl_pkg::PDL_SRC_FDX: led_next = full_duplex;
      // steady on link, dark half periods while traffic runs
      pdl_pkg::PDL_SRC_LINK_BLINK: led_next = link_up & ~(act_show & blink_phase);
      default: led_next = 1'b0;
    endcase
  end

  // registered so the pin never glitches on a config write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      led_out <= 1'b0;
    end else begin
      led_out <= led_next;
    end
  end

endmodule : pdl_led_drive
`default_nettype wire

// ### pdl_diag_led_assertions.sv
`default_nettype none
module pdl_diag_led_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic an_done,
  input wire logic an_fail,
  input wire logic rx_signal_detected,
  input wire logic rx_pll_lock,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rdata_valid,
  input wire logic [15:0] tx_gain
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic rd12;
  // read of the diagnostic word
  assign rd12 = mgmt_rd && mgmt_addr == 5'h12;
  rd_answer_a: assert property (mgmt_rd |=> mgmt_rdata_valid) else $error("no answer");
  answer_pulse_a: assert property (!mgmt_rd |=> !mgmt_rdata_valid) else $error("stray answer");
  fail_seen_a: assert property (an_done && an_fail ##1 !mgmt_rd ##1 rd12 |=> mgmt_rdata[12])
    else $error("fail lost");
  fail_clear_a: assert property (rd12 && !an_done ##1 rd12 |=> !mgmt_rdata[12]) else $error("no clear");
  diag_spare_a: assert property (rd12 |=> mgmt_rdata[15:13] == 3'h0 && mgmt_rdata[7:0] == 8'h00)
    else $error("spare set");
  rx_status_a: assert property (rd12 |=> mgmt_rdata[9:8] == $past({rx_signal_detected, rx_pll_lock}, 2))
    else $error("rx bits");
  led_upper_a: assert property (mgmt_rd && mgmt_addr == 5'h17 |=> mgmt_rdata[15:8] == 8'h00)
    else $error("led upper");
  gain_copy_a: assert property ($past(mgmt_wr && mgmt_addr == 5'h13, 2) |-> tx_gain == $past(mgmt_wdata, 2))
    else $error("gain copy");
  cover property (an_done && an_fail);
  cover property (rd12 ##1 rd12);
  cover property (mgmt_wr && mgmt_addr == 5'h17);
endmodule : pdl_diag_led_assertions
bind pdl_diag_led pdl_diag_led_assertions chk_i (.clk_sys, .rst_b, .mgmt_addr, .mgmt_rd, .mgmt_wr,
  .mgmt_wdata, .an_done, .an_fail, .rx_signal_detected, .rx_pll_lock, .mgmt_rdata, .mgmt_rdata_valid, .tx_gain);
`default_nettype wire

// ### pdl_sw_model.sv
`default_nettype none
module pdl_sw_model (
  input wire logic clk_sys,
  input wire logic [15:0] mgmt_rdata,
  output logic [4:0] mgmt_addr,
  output logic mgmt_rd,
  output logic mgmt_wr,
  output logic [15:0] mgmt_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {mgmt_addr, mgmt_rd, mgmt_wr, mgmt_wdata} = '0;
  // n reads back to back; answer is fixed one cycle late, so no wait loop
  task automatic rd(input logic [4:0] a, input int n, output logic [15:0] d);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    repeat (n) @(posedge clk_sys);
    mgmt_rd <= 1'b0;
    @(negedge clk_sys);
    d = mgmt_rdata;
  endtask : rd
  // released data is inverted so a stale word is never mistaken for valid
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_wr <= 1'b1;
    mgmt_wdata <= v;
    @(posedge clk_sys);
    mgmt_wr <= 1'b0;
    mgmt_wdata <= ~v;
  endtask : wr
endmodule : pdl_sw_model
`default_nettype wire

// ### pdl_diag_led_tb.sv
`default_nettype none
module pdl_diag_led_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_b = 0, an_done = 0, an_fail = 0, an_fdx = 0, an_spd = 0, rx_sd = 0, rx_lk = 0;
  logic link_up = 0, rx_act = 0, tx_act = 0, spd = 0, fdx = 0, rd, wr, vld, led_p, led_s;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, gain, d;
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  always #5 clk_sys = ~clk_sys;
  pdl_diag_led #(.BLINK_CYCLES(8)) uut (.clk_sys, .rst_b, .mgmt_addr(addr), .mgmt_rd(rd), .mgmt_wr(wr),
    .mgmt_wdata(wdata), .an_done, .an_fail, .an_full_duplex(an_fdx), .an_speed_100(an_spd),
    .rx_signal_detected(rx_sd), .rx_pll_lock(rx_lk), .link_up, .rx_activity(rx_act), .tx_activity(tx_act),
    .speed_100(spd), .full_duplex(fdx), .mgmt_rdata(rdata), .mgmt_rdata_valid(vld), .tx_gain(gain),
    .led_primary(led_p), .led_secondary(led_s));
  pdl_sw_model sw (.clk_sys, .mgmt_rdata(rdata), .mgmt_addr(addr), .mgmt_rd(rd), .mgmt_wr(wr), .mgmt_wdata(wdata));
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    sw.rd(a, 1, d);
    chk("rdata", e, d);
    chk("valid", 16'h0001, {15'h0000, vld});
  endtask : rchk
  // negotiation outcome pulse, one cycle
  task automatic neg(input logic f, input logic x, input logic y);
    @(posedge clk_sys);
    {an_done, an_fail, an_fdx, an_spd} <= {1'b1, f, x, y};
    @(posedge clk_sys);
    an_done <= 1'b0;
  endtask : neg
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // hang guard, well above the roughly 770 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(5'h12, 16'h0000);
    rchk(5'h13, 16'h4000);
    rchk(5'h17, 16'h0010);
    rchk(5'h15, 16'h0000);
    chk("gain", 16'h4000, gain);
    sw.wr(5'h12, 16'hFFFF);
    rchk(5'h12, 16'h0000);
    sw.wr(5'h13, 16'hA5C3);
    rchk(5'h13, 16'hA5C3);
    chk("gain", 16'hA5C3, gain);
    sw.wr(5'h17, 16'hFFFF);
    rchk(5'h17, 16'h00FF);
    @(posedge clk_sys) {rx_sd, rx_lk} <= 2'h3;
    neg(1'b0, 1'b1, 1'b1);
    rchk(5'h12, 16'h0F00);
    neg(1'b0, 1'b0, 1'b0);
    rchk(5'h12, 16'h0300);
    neg(1'b1, 1'b1, 1'b1);
    rchk(5'h12, 16'h1300);
    rchk(5'h12, 16'h0300);
    neg(1'b1, 1'b0, 1'b0);
    sw.rd(5'h12, 2, d);
    chk("rdata", 16'h0300, d);
    // split the two status bits, then a failure landing on a read: the set wins
    @(posedge clk_sys) {rx_sd, rx_lk} <= 2'h2;
    rchk(5'h12, 16'h0200);
    fork
      neg(1'b1, 1'b0, 1'b0);
      sw.rd(5'h12, 1, d);
    join
    chk("rdata", 16'h0200, d);
    rchk(5'h12, 16'h1200);
    rchk(5'h12, 16'h0200);
    // every code on both fields, under two opposite input sets
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys) {link_up, spd, fdx, rx_act} <= p ? 4'h3 : 4'hC;
      for (int c = 0; c < 16; c++) begin
        sw.wr(5'h17, {8'h00, c[3:0], c[3:0]});
        repeat (20) @(negedge clk_sys);
        n = ((p ? 16'h00C2 : 16'h0121) >> c) & 1;
        chk("led", {14'h0, n[0], n[0]}, {14'h0, led_s, led_p});
      end
    end
    @(posedge clk_sys) {link_up, rx_act, tx_act} <= 3'h5;
    sw.wr(5'h17, 16'h0088);
    repeat (20) @(negedge clk_sys);
    n = 0;
    repeat (16) @(negedge clk_sys) n += led_p;
    chk("blink", 16'h0008, n[15:0]);
    complete_run();
  end
endmodule : pdl_diag_led_tb
`default_nettype wire
